/* File: rtl/fpu_ctx_ctrl.sv */
`default_nettype none
// How it works
// [RL1] The unit leaves reset disabled and software enables it.
// [RL2] A floating-point issue while disabled is dropped and raises a coprocessor_absent_fault.
// [RL3] Context handling selects none, always-save or lazy save.
// [RL4] With no saving the frame is the eight integer words only.
// [RL5] Always-save writes the floating-point context on every interrupt entry.
// [RL6] Lazy handling is selected after reset.
// [RL7] Lazy entry reserves the space but writes only integer state.
// [RL8] In lazy mode the first handler floating-point issue fills the space before it executes.
// [RL9] Lazy return reloads the context only if it was written in that handler.
// [RL10] Six arithmetic exceptions are detected as interrupt sources.
// [RL11] Each exception interrupt is enabled on its own; disabled ones raise nothing.
// [RL12] Half format, NaN handling, flush-to-zero and rounding are adjustable settings.
// [RL13] Full stacking enlarges the frame from eight to twenty-six words.
// [RL14] Rounding offers four choices with nearest as reset default.
// [RL15] Reset leaves flush-to-zero off, NaNs propagating and IEEE half format.
// [RL16] All control bits are software writable and reset to defaults.
// [RL17] Each exception sets a sticky flag until software clears it, enabled or not.
module fpu_ctx_ctrl
	import fpu_ctx_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_cfg_we,
	input wire logic i_fpu_en,
	input wire ctx_mode_e i_ctx_mode,
	input wire arith_mode_s i_arith,
	input wire exc_t i_exc_en,
	input wire exc_t i_exc_clr,
	input wire logic i_fp_issue,
	input wire logic i_save_done,
	input wire logic i_irq_entry,
	input wire logic i_irq_return,
	input wire exc_t i_exc_event,
	output logic o_fpu_en,
	output ctx_mode_e o_ctx_mode,
	output arith_mode_s o_arith,
	output exc_t o_exc_en,
	output exc_t o_exc_flags,
	output logic o_exc_irq,
	output logic o_fp_exec,
	output logic o_coprocessor_absent_fault,
	output logic o_fp_stall,
	output logic o_save_req,
	output logic o_restore_req,
	output logic [4:0] o_frame_words,
	output logic o_entry_fp_write
);
	// ****************************************
	// Control bits
	// ****************************************
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_fpu_en <= RST_FPU_EN; // see [RL1]
			o_ctx_mode <= RST_CTX_MODE; // see [RL6]
			o_arith <= RST_ARITH; // see [RL14] see [RL15]
			o_exc_en <= RST_EXC_EN;
		end else if (i_ce && i_cfg_we) begin
			o_fpu_en <= i_fpu_en; // see [RL16]
			// Unused code falls back to lazy so a bad write cannot disable saving
			o_ctx_mode <= (i_ctx_mode == 2'h3) ? CTX_LAZY : i_ctx_mode; // see [RL3]
			o_arith <= i_arith; // see [RL12]
			o_exc_en <= i_exc_en; // see [RL11]
		end
	end

	// ****************************************
	// Issue gating and lazy state
	// ****************************************
	logic lazy_pend_r;
	logic lazy_saved_r;
	logic lazy_go;
	assign lazy_go = o_fpu_en && i_fp_issue && lazy_pend_r;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_fp_exec <= 1'b0;
			o_coprocessor_absent_fault <= 1'b0;
		end else if (i_ce) begin
			o_coprocessor_absent_fault <= i_fp_issue && !o_fpu_en; // see [RL2]
			// Held back while the reserved frame is filled
			o_fp_exec <= o_fpu_en && i_fp_issue && !lazy_pend_r && !o_fp_stall; // see [RL8]
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			lazy_pend_r <= 1'b0;
			lazy_saved_r <= 1'b0;
			o_fp_stall <= 1'b0;
			o_save_req <= 1'b0;
		end else if (i_ce) begin
			o_save_req <= 1'b0;
			if (i_irq_entry) begin
				lazy_pend_r <= (o_ctx_mode == CTX_LAZY); // see [RL7]
				lazy_saved_r <= 1'b0;
			end else if (lazy_go && !o_fp_stall) begin
				o_fp_stall <= 1'b1; // see [RL8]
				o_save_req <= 1'b1;
			end else if (o_fp_stall && i_save_done) begin
				o_fp_stall <= 1'b0;
				lazy_pend_r <= 1'b0;
				lazy_saved_r <= 1'b1; // see [RL9]
			end else if (i_irq_return) begin
				lazy_pend_r <= 1'b0;
				lazy_saved_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// Entry frame and return restore
	// ****************************************
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_frame_words <= FRAME_INT_WORDS;
			o_entry_fp_write <= 1'b0;
			o_restore_req <= 1'b0;
		end else if (i_ce) begin
			o_entry_fp_write <= i_irq_entry && o_ctx_mode == CTX_ALWAYS; // see [RL5]
			o_restore_req <= i_irq_return && (o_ctx_mode == CTX_ALWAYS ||
				(o_ctx_mode == CTX_LAZY && lazy_saved_r)); // see [RL9]
			if (i_irq_entry)
				o_frame_words <= (o_ctx_mode == CTX_NONE) ? FRAME_INT_WORDS
					: FRAME_FP_WORDS; // see [RL4] see [RL13]
		end
	end

	// ****************************************
	// Exception flags and interrupt
	// ****************************************
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_exc_flags <= '0;
			o_exc_irq <= 1'b0;
		end else if (i_ce) begin
			// Set wins over a clear in the same cycle
			o_exc_flags <= (o_exc_flags & ~i_exc_clr) | i_exc_event; // see [RL10] see [RL17]
			o_exc_irq <= |(((o_exc_flags & ~i_exc_clr) | i_exc_event) & o_exc_en); // see [RL11]
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	a_fault_when_off: assert property ( // see [RL2]
		i_ce && i_fp_issue && !o_fpu_en |=> o_coprocessor_absent_fault && !o_fp_exec)
		else $error("missing fault");
	a_no_fault_on: assert property ( // see [RL2]
		i_ce && i_fp_issue && o_fpu_en |=> !o_coprocessor_absent_fault)
		else $error("fault while enabled");
	a_reset_disabled: assert property ( // see [RL1]
		$rose(o_fpu_en) |-> $past(i_cfg_we))
		else $error("enable without write");
	a_exec_needs_en: assert property ( // see [RL1]
		o_fp_exec |-> $past(o_fpu_en))
		else $error("exec while disabled");
	a_mode_legal: assert property ( // see [RL3]
		o_ctx_mode != 2'h3)
		else $error("bad mode");

	// ****************************************
	// Frame and lazy save checks
	// ****************************************
	// An executing issue must have seen no pending lazy save one cycle before
	a_lazy_save_first: assert property ( // see [RL8]
		o_fp_exec |-> $past(!lazy_pend_r))
		else $error("exec before lazy save");
	a_save_lazy_only: assert property ( // see [RL7]
		o_save_req |-> $past(lazy_pend_r))
		else $error("save outside lazy");
	a_save_req_once: assert property ( // see [RL8]
		o_save_req |=> !o_save_req)
		else $error("save request repeated");
	a_stall_on_save: assert property ( // see [RL8]
		o_save_req |-> o_fp_stall)
		else $error("save without stall");
	a_none_frame: assert property ( // see [RL4]
		i_ce && i_irq_entry && o_ctx_mode == CTX_NONE |=>
		o_frame_words == FRAME_INT_WORDS && !o_entry_fp_write) else $error("bad none frame");
	a_full_frame: assert property ( // see [RL5]
		i_ce && i_irq_entry && o_ctx_mode == CTX_ALWAYS |=>
		o_frame_words == FRAME_FP_WORDS && o_entry_fp_write) else $error("bad full frame");
	a_lazy_entry: assert property ( // see [RL7]
		i_ce && i_irq_entry && o_ctx_mode == CTX_LAZY |=>
		o_frame_words == FRAME_FP_WORDS && !o_entry_fp_write) else $error("bad lazy frame");
	a_frame_range: assert property ( // see [RL13]
		o_frame_words == FRAME_INT_WORDS || o_frame_words == FRAME_FP_WORDS)
		else $error("bad frame size");
	a_always_restore: assert property ( // see [RL5]
		i_ce && i_irq_return && o_ctx_mode == CTX_ALWAYS |=> o_restore_req)
		else $error("missing full restore");
	a_none_restore: assert property ( // see [RL4]
		i_ce && i_irq_return && o_ctx_mode == CTX_NONE |=> !o_restore_req)
		else $error("restore with no saving");
	a_lazy_restore: assert property ( // see [RL9]
		i_ce && i_irq_return && o_ctx_mode == CTX_LAZY && !lazy_saved_r |=> !o_restore_req)
		else $error("spurious restore");
	a_lazy_reload: assert property ( // see [RL9]
		i_ce && i_irq_return && o_ctx_mode == CTX_LAZY && lazy_saved_r |=> o_restore_req)
		else $error("missing lazy restore");

	// ****************************************
	// Exception and freeze checks
	// ****************************************
	a_flag_sticky: assert property ( // see [RL17]
		i_ce && (i_exc_event[0] || (o_exc_flags[0] && !i_exc_clr[0])) |=> o_exc_flags[0])
		else $error("flag lost");
	a_set_beats_clr: assert property ( // see [RL17]
		i_ce && i_exc_event[1] |=> o_exc_flags[1])
		else $error("set lost to clear");
	a_irq_masked: assert property ( // see [RL11]
		o_exc_irq |-> $past(o_exc_en) != '0)
		else $error("masked irq");
	a_irq_enabled: assert property ( // see [RL11]
		i_ce && (|(i_exc_event & o_exc_en)) |=> o_exc_irq)
		else $error("missing irq");
	// A frozen block must not lose a flag or a half-done lazy save
	a_ce_freeze: assert property ( // see [RL16]
		!i_ce |=> $stable(o_exc_flags) && $stable(o_fpu_en) && $stable(o_fp_stall))
		else $error("state moved while frozen");

	c_fault: cover property (o_coprocessor_absent_fault);
	c_lazy_save: cover property (o_save_req ##[1:20] o_restore_req);
	c_irq: cover property (o_exc_irq);
	c_full_entry: cover property (o_entry_fp_write);
	c_set_clear: cover property (i_exc_event[0] && i_exc_clr[0]);
endmodule
`default_nettype wire

/* File: rtl/fpu_ctx_pkg.sv */
`default_nettype none
package fpu_ctx_pkg;
	// ****************************************
	// Context handling and arithmetic modes
	// ****************************************
	typedef enum logic [1:0] {CTX_NONE, CTX_ALWAYS, CTX_LAZY} ctx_mode_e;
	typedef enum logic [1:0] {RND_NEAREST, RND_POS_INF, RND_NEG_INF, RND_ZERO} rnd_mode_e;

	typedef struct packed {
		logic half_alt;
		logic nan_default;
		logic flush_zero;
		rnd_mode_e rounding;
	} arith_mode_s;

	// Exception bits: underflow, overflow, div0, invalid, input denormal, inexact
	localparam int EXC_W = 6;
	typedef logic [EXC_W-1:0] exc_t;

	localparam logic RST_FPU_EN = 1'b0;
	localparam ctx_mode_e RST_CTX_MODE = CTX_LAZY;
	localparam arith_mode_s RST_ARITH = '{half_alt: 1'b0, nan_default: 1'b0,
		flush_zero: 1'b0, rounding: RND_NEAREST};
	localparam exc_t RST_EXC_EN = 6'h00;

	localparam logic [4:0] FRAME_INT_WORDS = 5'h08;
	localparam logic [4:0] FRAME_FP_WORDS = 5'h1A;
endpackage
`default_nettype wire

/* File: tb/core_model.sv */
`default_nettype none
// ****
// Core side: fills the reserved frame on request
// ****
module core_model #(
	parameter int DELAY = 3
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_save_req,
	output logic o_save_done
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt_r;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r <= 0;
			o_save_done <= 1'b0;
		end else begin
			o_save_done <= (cnt_r == 1);
			if (i_save_req)
				cnt_r <= DELAY;
			else if (cnt_r != 0)
				cnt_r <= cnt_r - 1;
		end
	end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
// ****
// Bench
// ****
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import fpu_ctx_pkg::*;
	logic clk = 0, rst = 1, we = 0, en = 0, iss = 0, ent = 0, ret = 0, ce = 1;
	ctx_mode_e md = CTX_LAZY;
	arith_mode_s ar = RST_ARITH;
	exc_t xen = '0, xclr = '0, xev = '0, x_en, x_fl;
	ctx_mode_e c_md;
	arith_mode_s f_ar;
	logic f_en, irq, exe, flt, stl, sreq, rreq, efw, done;
	logic [4:0] fw;
	int errors = 0, checked = 0;
	always #10 clk = ~clk;
	fpu_ctx_ctrl fpu_ctx_ctrl_inst (.i_mclk(clk), .i_rst(rst), .i_ce(ce), .i_cfg_we(we),
		.i_fpu_en(en), .i_ctx_mode(md), .i_arith(ar), .i_exc_en(xen), .i_exc_clr(xclr),
		.i_fp_issue(iss), .i_save_done(done), .i_irq_entry(ent), .i_irq_return(ret),
		.i_exc_event(xev), .o_fpu_en(f_en), .o_ctx_mode(c_md), .o_arith(f_ar),
		.o_exc_en(x_en), .o_exc_flags(x_fl), .o_exc_irq(irq), .o_fp_exec(exe),
		.o_coprocessor_absent_fault(flt), .o_fp_stall(stl), .o_save_req(sreq),
		.o_restore_req(rreq), .o_frame_words(fw), .o_entry_fp_write(efw));
	core_model core_model_inst (.i_mclk(clk), .i_rst(rst), .i_save_req(sreq),
		.o_save_done(done));
	task stop_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task cfg(input ctx_mode_e m);
		@(negedge clk);
		en = 1'b1;
		md = m;
		we = 1'b1;
		@(negedge clk);
		we = 1'b0;
	endtask
	task pulse_ev(input exc_t v);
		xev = v;
		@(negedge clk);
		xev = '0;
		@(negedge clk);
	endtask
	// Bounded so a stuck design cannot hang the run
	initial begin
		#100us;
		errors++;
		stop_test();
	end
	initial begin
		repeat (20) @(negedge clk);
		rst = 0;
		`CHK("fpu_en", 1'b0, f_en)
		`CHK("ctx", CTX_LAZY, c_md)
		`CHK("arith", RST_ARITH, f_ar)
		`CHK("exc_en", RST_EXC_EN, x_en)
		iss = 1'b1;
		@(negedge clk);
		`CHK("fault", 1'b1, flt)
		`CHK("exec", 1'b0, exe)
		iss = 1'b0;
		$display("test reset and disabled issue done");
		xen = 6'h04;
		for (int i = 0; i < 3; i++) begin
			cfg(ctx_mode_e'(i));
			ent = 1'b1;
			@(negedge clk);
			ent = 1'b0;
			`CHK("frame", (i == 0) ? FRAME_INT_WORDS : FRAME_FP_WORDS, fw)
			`CHK("entry_wr", (i == 1), efw)
			ret = 1'b1;
			@(negedge clk);
			ret = 1'b0;
			`CHK("restore", (i == 1), rreq)
		end
		`CHK("exc_en", 6'h04, x_en)
		ent = 1'b1;
		@(negedge clk);
		ent = 1'b0;
		iss = 1'b1;
		@(negedge clk);
		`CHK("save_req", 1'b1, sreq)
		`CHK("stall", 1'b1, stl)
		`CHK("exec", 1'b0, exe)
		for (int k = 0; k < 20 && exe !== 1'b1; k++)
			@(negedge clk);
		`CHK("exec", 1'b1, exe)
		`CHK("stall", 1'b0, stl)
		iss = 1'b0;
		ret = 1'b1;
		@(negedge clk);
		ret = 1'b0;
		`CHK("restore", 1'b1, rreq)
		$display("test context handling done");
		for (int r = 0; r < 4; r++) begin
			ar = '{r[0], r[1], 1'b1, rnd_mode_e'(r)};
			cfg(CTX_LAZY);
			`CHK("arith", ar, f_ar)
		end
		cfg(ctx_mode_e'(2'h3));
		`CHK("ctx_code3", CTX_LAZY, c_md)
		pulse_ev(6'h01);
		`CHK("flags", 6'h01, x_fl)
		`CHK("irq", 1'b0, irq)
		pulse_ev(6'h3E);
		`CHK("flags", 6'h3F, x_fl)
		`CHK("irq", 1'b1, irq)
		xclr = 6'h3F;
		@(negedge clk);
		xclr = '0;
		@(negedge clk);
		`CHK("flags", 6'h00, x_fl)
		`CHK("irq", 1'b0, irq)
		xclr = 6'h01;
		xev = 6'h01;
		@(negedge clk);
		xclr = '0;
		xev = '0;
		@(negedge clk);
		`CHK("set_wins", 6'h01, x_fl)
		xclr = 6'h01;
		@(negedge clk);
		xclr = '0;
		ce = 1'b0;
		xev = 6'h3F;
		@(negedge clk);
		xev = '0;
		ce = 1'b1;
		@(negedge clk);
		`CHK("frozen", 6'h00, x_fl)
		$display("test modes and exceptions done");
		stop_test();
	end
endmodule
`default_nettype wire
